// [eil_cpu_model.sv]
// cpu side model: priority logic fetching the vector of this interrupt
`timescale 1ns/1ns
`default_nettype none
`include "eil_map.svh"
module eil_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic fetch_en,
  input wire logic cpu_irq_req,
  output logic vec_fetch_ack
);
  logic [1:0] wait_q;
  logic [15:0] vec_q;
  // fetch three cycles after the request; no masking in the routine, kept simple
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_q <= 2'h0;
      vec_fetch_ack <= 1'b0;
    end else begin
      vec_fetch_ack <= 1'b0;
      wait_q <= (cpu_irq_req && fetch_en) ? wait_q + 2'h1 : 2'h0;
      if (wait_q == 2'h2) begin
        vec_fetch_ack <= 1'b1;
        vec_q <= `EIL_VEC_HI;
        wait_q <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// [eil_latch.sv]
// external interrupt latch with status/control register and event interrupt
`timescale 1ns/1ns
`default_nettype none
`include "eil_map.svh"

module eil_latch import eil_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq_pin_n,
  input wire logic vec_fetch_ack,
  input wire logic break_state,
  input wire logic [`EIL_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic cpu_irq_req,
  output logic irq
);
  localparam logic [15:0] VEC_HI = `EIL_VEC_HI; // vector high byte address
  localparam logic [15:0] VEC_LO = `EIL_VEC_LO; // vector low byte address

  eil_state_s q;
  eil_state_s d;

  // register field read helper
  function automatic logic [7:0] rd_mux(input eil_state_s s, input logic [`EIL_ADDR_W-1:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `EIL_OFF_SCR: begin
        r[`EIL_BIT_MODE] = s.mode;
        r[`EIL_BIT_MASK] = s.mask;
        r[`EIL_BIT_ACK] = 1'b0;
        r[`EIL_BIT_PEND] = s.latch;
      end
      `EIL_OFF_IRQ_STAT: r[1:0] = s.ev_stat;
      `EIL_OFF_IRQ_MASK: r[1:0] = s.ev_mask;
      `EIL_OFF_BRK_CTRL: r[`EIL_BIT_BREAK_CLEAR_ENABLE] = s.break_clear_enable;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // falling edge seen between two successive pin samples
  function automatic logic fell_edge(input logic prev, input logic cur);
    return prev && !cur;
  endfunction

  logic scr_wr;
  logic sw_ack;
  logic fall;
  logic set_ev;
  logic clr_ev;
  logic [1:0] ev_set;

  // next-state logic
  always_comb begin
    d = q;
    scr_wr = wr && (addr == `EIL_OFF_SCR);
    // ack write ignored in break unless break-clear is enabled
    sw_ack = scr_wr && wdata[`EIL_BIT_ACK] && (!break_state || q.break_clear_enable);
    // two-stage sync; edge taken from second and third stages only
    d.pin_s1 = irq_pin_n;
    d.pin_s2 = q.pin_s1;
    d.pin_prev = q.pin_s2;
    fall = fell_edge(q.pin_prev, q.pin_s2);
    // level mode: a low pin keeps setting the latch, so ack only sticks once high
    set_ev = fall || (q.mode && !q.pin_s2);
    clr_ev = vec_fetch_ack || sw_ack;
    // a fresh edge always wins and forgets an older acknowledge
    if (fall) begin
      d.latch = 1'b1;
      d.ack_seen = 1'b0;
    end else if (set_ev) begin
      // pin still low: keep pending, but remember the acknowledge for later
      d.latch = 1'b1;
      d.ack_seen = q.ack_seen || clr_ev;
    end else if (clr_ev || q.ack_seen) begin
      d.latch = 1'b0;
      d.ack_seen = 1'b0;
    end
    if (scr_wr) begin
      d.mode = wdata[`EIL_BIT_MODE];
      d.mask = wdata[`EIL_BIT_MASK];
    end
    if (wr && addr == `EIL_OFF_BRK_CTRL) begin
      d.break_clear_enable = wdata[`EIL_BIT_BREAK_CLEAR_ENABLE];
    end
    if (wr && addr == `EIL_OFF_IRQ_MASK) begin
      d.ev_mask = wdata[1:0];
    end
    // sticky events; a set in the clearing cycle wins
    ev_set = 2'b00;
    ev_set[`EIL_BIT_EV_LATCH] = d.latch && !q.latch;
    ev_set[`EIL_BIT_EV_ACK] = q.latch && !d.latch;
    if (wr && addr == `EIL_OFF_IRQ_STAT) begin
      d.ev_stat = q.ev_stat & ~wdata[1:0];
    end
    d.ev_stat = d.ev_stat | ev_set;
    d.rdata = rd ? rd_mux(q, addr) : 8'h00;
    // the CPU then fetches its vector from VEC_HI/VEC_LO
    d.cpu_req = d.latch && !d.mask;
    d.sys_irq = |(d.ev_stat & ~d.ev_mask);
  end

  // state register, synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      // sync keeps tracking the pin, so a pin held low gives no false edge
      q.pin_s1 <= irq_pin_n;
      q.pin_s2 <= q.pin_s1;
      q.pin_prev <= q.pin_s2;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign cpu_irq_req = q.cpu_req;
  assign irq = q.sys_irq;

  initial begin
    if (VEC_LO != VEC_HI + 16'h0001) $error("vector bytes not adjacent");
  end

  // mask keeps the request away from the priority logic
  a_mask_gates_req: assert property (@(posedge clk) disable iff (rst)
    q.mask |-> !cpu_irq_req)
    else $error("masked request reached cpu");

  // an unmasked latch is forwarded
  a_unmasked_forwards: assert property (@(posedge clk) disable iff (rst)
    (q.latch && !q.mask) |-> cpu_irq_req)
    else $error("unmasked request not forwarded");

  // nothing latched, nothing requested
  a_req_low_unlatched: assert property (@(posedge clk) disable iff (rst)
    !q.latch |-> !cpu_irq_req)
    else $error("request without latch");

  // writing the mask bit drops the request at once
  a_mask_write_req: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `EIL_OFF_SCR && wdata[`EIL_BIT_MASK]) |=> !cpu_irq_req)
    else $error("mask write did not withhold");

  // pending flag follows the latch
  a_pend_visible: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == `EIL_OFF_SCR) |=> rdata[`EIL_BIT_PEND] == $past(q.latch))
    else $error("pending flag wrong");

  // polling still sees a masked request
  a_pend_masked: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == `EIL_OFF_SCR && q.mask && q.latch) |=> rdata[`EIL_BIT_PEND])
    else $error("masked request hidden from polling");

  // acknowledge bit never reads back
  a_ack_reads_zero: assert property (@(posedge clk) disable iff (rst)
    rd |=> !rdata[`EIL_BIT_ACK])
    else $error("ack bit read as one");

  // mask bit reads back as stored
  a_mask_readback: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == `EIL_OFF_SCR) |=> rdata[`EIL_BIT_MASK] == $past(q.mask))
    else $error("mask bit read wrong");

  // mask bit is written
  a_mask_write: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `EIL_OFF_SCR) |=> q.mask == $past(wdata[`EIL_BIT_MASK]))
    else $error("mask write lost");

  // sensitivity bit is written
  a_mode_write: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `EIL_OFF_SCR) |=> q.mode == $past(wdata[`EIL_BIT_MODE]))
    else $error("mode write lost");

  // sensitivity bit reads back as stored
  a_mode_readback: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == `EIL_OFF_SCR) |=> rdata[`EIL_BIT_MODE] == $past(q.mode))
    else $error("mode bit read wrong");

  // a synchronised falling edge sets the latch
  a_edge_latches: assert property (@(posedge clk) disable iff (rst)
    fell_edge(q.pin_prev, q.pin_s2) |=> q.latch)
    else $error("edge not latched");

  // no low, no latch
  a_no_spurious_set: assert property (@(posedge clk) disable iff (rst)
    (!q.latch && !fell_edge(q.pin_prev, q.pin_s2) && !(q.mode && !q.pin_s2))
    |=> !q.latch)
    else $error("latch set without low pin");

  // edge mode ignores a pin that merely stays low
  a_edge_only: assert property (@(posedge clk) disable iff (rst)
    (!q.mode && !q.latch && !fell_edge(q.pin_prev, q.pin_s2)) |=> !q.latch)
    else $error("edge mode latched on level");

  // vector fetch clears an edge request
  a_vec_clears: assert property (@(posedge clk) disable iff (rst)
    (vec_fetch_ack && !q.mode && !fell_edge(q.pin_prev, q.pin_s2)) |=> !q.latch)
    else $error("vector fetch did not clear");

  // software acknowledge outside break clears an edge request
  a_sw_ack_clears: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `EIL_OFF_SCR && wdata[`EIL_BIT_ACK] && !break_state && !q.mode
    && !fell_edge(q.pin_prev, q.pin_s2)) |=> !q.latch)
    else $error("software ack did not clear");

  // protected break: a software acknowledge leaves the latch alone
  a_break_protect: assert property (@(posedge clk) disable iff (rst)
    (q.latch && break_state && !q.break_clear_enable && !vec_fetch_ack && !q.ack_seen) |=> q.latch)
    else $error("latch cleared in protected break");

  // break with clear enabled lets software clear
  a_break_clear: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `EIL_OFF_SCR && wdata[`EIL_BIT_ACK] && break_state && q.break_clear_enable
    && !q.mode && !fell_edge(q.pin_prev, q.pin_s2)) |=> !q.latch)
    else $error("break clear did not clear");

  // leaving break does not bring a cleared latch back
  a_exit_no_set: assert property (@(posedge clk) disable iff (rst)
    ($past(break_state) && !break_state && !q.latch && !(q.mode && !q.pin_s2)
    && !fell_edge(q.pin_prev, q.pin_s2)) |=> !q.latch)
    else $error("latch returned after break");

  // break-clear enable is written
  a_break_clear_enable_write: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `EIL_OFF_BRK_CTRL) |=> q.break_clear_enable == $past(wdata[`EIL_BIT_BREAK_CLEAR_ENABLE]))
    else $error("break clear write lost");

  // break-clear enable reads back
  a_break_clear_enable_readback: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == `EIL_OFF_BRK_CTRL) |=> rdata[`EIL_BIT_BREAK_CLEAR_ENABLE] == $past(q.break_clear_enable))
    else $error("break clear read wrong");

  // level mode: low pin keeps the request
  a_level_holds: assert property (@(posedge clk) disable iff (rst)
    (q.mode && !q.pin_s2) |=> q.latch)
    else $error("level request dropped");

  // level mode: vector fetch on a low pin does not clear
  a_vec_pends_level: assert property (@(posedge clk) disable iff (rst)
    (vec_fetch_ack && q.mode && !q.pin_s2) |=> q.latch)
    else $error("level request cleared while low");

  // level mode: an early acknowledge is remembered
  a_level_ack_held: assert property (@(posedge clk) disable iff (rst)
    (q.mode && !q.pin_s2 && vec_fetch_ack && !fell_edge(q.pin_prev, q.pin_s2))
    |=> q.ack_seen)
    else $error("early acknowledge forgotten");

  // level mode: remembered acknowledge clears once the pin is high
  a_level_release: assert property (@(posedge clk) disable iff (rst)
    (q.mode && q.pin_s2 && q.ack_seen) |=> !q.latch)
    else $error("level request not released");

  // a remembered acknowledge only exists beside a set latch
  a_ack_seen_latched: assert property (@(posedge clk) disable iff (rst)
    q.ack_seen |-> q.latch)
    else $error("acknowledge remembered without latch");

  // edge after an acknowledge write latches again
  a_fresh_edge: assert property (@(posedge clk) disable iff (rst)
    (fell_edge(q.pin_prev, q.pin_s2) && $past(wr && addr == `EIL_OFF_SCR
    && wdata[`EIL_BIT_ACK])) |=> q.latch)
    else $error("edge after ack lost");

  // a new edge in level mode starts a fresh request
  a_fall_in_level: assert property (@(posedge clk) disable iff (rst)
    (q.mode && fell_edge(q.pin_prev, q.pin_s2)) |=> (q.latch && !q.ack_seen))
    else $error("level edge kept old acknowledge");

  // synchroniser stages shift one per clock
  a_sync_stage: assert property (@(posedge clk) disable iff (rst)
    q.pin_s2 == $past(q.pin_s1))
    else $error("second sync stage skipped");

  // edge history stage follows the second stage
  a_prev_stage: assert property (@(posedge clk) disable iff (rst)
    q.pin_prev == $past(q.pin_s2))
    else $error("edge history stage skipped");

  // edge reaches the cpu side in the same clock as the latch; checked one clock later
  a_sync_to_edge: assert property (@(posedge clk) disable iff (rst)
    ($fell(q.pin_s2) && !q.latch) |=> q.latch ##1 (q.mask || cpu_irq_req))
    else $error("request did not reach cpu");

  // reset clears latch and sensitivity even with the pin low
  a_reset_clears_latch: assert property (@(posedge clk)
    rst |=> (!q.latch && !q.mode && !q.ack_seen))
    else $error("reset left latch set");

  // reset clears mask and break-clear enable
  a_reset_clears_mask: assert property (@(posedge clk)
    rst |=> (!q.mask && !q.break_clear_enable))
    else $error("reset left mask set");

  // outputs quiet after reset
  a_reset_quiet_outs: assert property (@(posedge clk)
    rst |=> (rdata == 8'h00 && !cpu_irq_req && !irq))
    else $error("outputs active after reset");
endmodule
`default_nettype wire

// [eil_map.svh]
// register offsets, field positions and reset values of the external interrupt latch
`ifndef EIL_MAP_SVH
`define EIL_MAP_SVH
`define EIL_ADDR_W 4
`define EIL_OFF_SCR 4'h0
`define EIL_OFF_IRQ_STAT 4'h1
`define EIL_OFF_IRQ_MASK 4'h2
`define EIL_OFF_BRK_CTRL 4'h3
`define EIL_BIT_MODE 0
`define EIL_BIT_MASK 1
`define EIL_BIT_ACK 2
`define EIL_BIT_PEND 3
`define EIL_BIT_BREAK_CLEAR_ENABLE 0
`define EIL_BIT_EV_LATCH 0
`define EIL_BIT_EV_ACK 1
`define EIL_VEC_HI 16'hFFFA
`define EIL_VEC_LO 16'hFFFB
`define EIL_RST_BYTE 8'h00
`endif

// [eil_pkg.sv]
// types of the external interrupt latch
package eil_pkg;
  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic latch;
    logic ack_seen;
    logic mode;
    logic mask;
    logic break_clear_enable;
    logic [1:0] ev_stat;
    logic [1:0] ev_mask;
    logic [7:0] rdata;
    logic cpu_req;
    logic sys_irq;
  } eil_state_s;
endpackage

// [tb_eil_latch.sv]
// self-checking bench of the external interrupt latch
`timescale 1ns/1ns
`default_nettype none
`include "eil_map.svh"
module tb_eil_latch;
  logic clk = 0, rst = 1, pin_n = 1, brk = 0, wr = 0, rd = 0, fen = 0, m;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic req, irq, ack;
  logic [31:0] lfsr = 32'hCD11;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  always #5 clk = ~clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  eil_latch u_dut (.clk(clk), .rst(rst), .irq_pin_n(pin_n), .vec_fetch_ack(ack),
    .break_state(brk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cpu_irq_req(req), .irq(irq));
  eil_cpu_model u_cpu (.clk(clk), .rst(rst), .fetch_en(fen), .cpu_irq_req(req),
    .vec_fetch_ack(ack));
  function automatic logic [7:0] scr(input logic md, input logic mk, input logic pd);
    return {4'h0, pd, 1'b0, mk, md};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, exp);
  endtask
  task automatic pin(input logic v, input int n);
    @(posedge clk);
    pin_n <= v;
    repeat (n) @(posedge clk);
  endtask
  task automatic end_sim;
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // a hang is cut short well beyond the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rreg(`EIL_OFF_SCR, scr(0, 0, 0));
    rreg(4'h9, 8'h00);
    // random mask, fresh edge after every acknowledge
    repeat (6) begin
      lfsr = lfsr_next(lfsr);
      m = lfsr[0];
      wreg(`EIL_OFF_SCR, scr(0, m, 0));
      pin(1'b0, 5);
      chk("req", {7'h0, req}, {7'h0, ~m});
      rreg(`EIL_OFF_SCR, scr(0, m, 1));
      wreg(`EIL_OFF_SCR, scr(0, m, 0) | 8'h04);
      rreg(`EIL_OFF_SCR, scr(0, m, 0));
      pin(1'b1, 2 + int'(lfsr[3:1]));
    end
    chk("irq", {7'h0, irq}, 8'h01);
    wreg(`EIL_OFF_IRQ_MASK, 8'h03);
    #1 chk("irq", {7'h0, irq}, 8'h00);
    wreg(`EIL_OFF_IRQ_MASK, 8'h00);
    wreg(`EIL_OFF_IRQ_STAT, 8'h03);
    #1 chk("irq", {7'h0, irq}, 8'h00);
    fen <= 1'b1;
    wreg(`EIL_OFF_SCR, 8'h00);
    pin(1'b0, 10);
    rreg(`EIL_OFF_SCR, scr(0, 0, 0));
    fen <= 1'b0;
    pin(1'b1, 3);
    wreg(`EIL_OFF_SCR, scr(1, 0, 0));
    pin(1'b0, 5);
    wreg(`EIL_OFF_SCR, scr(1, 0, 0) | 8'h04);
    rreg(`EIL_OFF_SCR, scr(1, 0, 1));
    pin(1'b1, 5);
    rreg(`EIL_OFF_SCR, scr(1, 0, 0));
    pin(1'b0, 5);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rreg(`EIL_OFF_SCR, scr(0, 0, 0));
    repeat (4) @(posedge clk);
    rreg(`EIL_OFF_SCR, scr(0, 0, 0));
    pin(1'b1, 3);
    brk <= 1'b1;
    pin(1'b0, 5);
    wreg(`EIL_OFF_SCR, 8'h04);
    rreg(`EIL_OFF_SCR, scr(0, 0, 1));
    wreg(`EIL_OFF_BRK_CTRL, 8'h01);
    wreg(`EIL_OFF_SCR, 8'h04);
    brk <= 1'b0;
    rreg(`EIL_OFF_SCR, scr(0, 0, 0));
    end_sim();
  end
endmodule
`default_nettype wire
